// [src/lcd_cmd_consts.vh]
// Opcodes, reset values and bounds for the window and trim command block
`ifndef LCD_CMD_CONSTS_VH
`define LCD_CMD_CONSTS_VH
`define OP_BIAS_MASK 8'hfc
`define OP_BIAS 8'he8
`define OP_COM_END 8'hf1
`define OP_WIN_COL_START 8'hf4
`define OP_WIN_ROW_START 8'hf5
`define OP_WIN_COL_END 8'hf6
`define OP_WIN_ROW_END 8'hf7
`define OP_WIN_MODE_MASK 8'hfe
`define OP_WIN_MODE 8'hf8
`define OP_TRIM_CTRL 8'hb8
`define OP_TRIM_MASK 8'hb9
`define OP_DISP_EN_MASK 8'hf8
`define OP_DISP_EN 8'ha8
`define OP_MAP_MASK 8'hf8
`define OP_MAP 8'hc0
`define TRIM_EN_BIT 3
`define TRIM_VALID_BIT 4
`define TRIM_OP_IDLE 3'h0
`define TRIM_OP_READ 3'h1
`define TRIM_OP_ERASE 3'h2
`define TRIM_OP_PROGRAM 3'h3
`define COL_MAX 7'h7f
`define ROW_MAX 8'h9f
`define RST_BIAS 2'h0
`define RST_COM_END 8'h9f
`define RST_PART_START 8'h00
`define RST_PART_END 8'h9f
`define RST_WIN_COL_END 7'h7f
`define RST_WIN_ROW_END 8'h9f
`define RST_MUX_RATE 9'h0a0
`endif

// [src/lcd_window_cmd.v]
// Command decoder for bias, COM range, program window and trim control
//
// Summary of operation
// - Bias command loads two-bit ratio select
// - COM end second byte sets last index
// - Partial start and end pick active COMs
// - Indices zero-based, never change RAM row mapping
// - Partial mux rate from start, end, fixed rows
// - Four two-byte commands load window bounds
// - Inside mode wraps pointers at window bounds
// - Outside mode wraps over full RAM map
// - Outside mode drops writes inside window
// - Boundary step chooses advancing next line
// - Row direction reverse flips row stepping
// - Order bit picks row or column first
// - Mirror maps columns to 127 minus address
// - Mode change keeps pointers, host reloads
// - Trim control low bits select operation
// - Trim enable clears when operation completes
// - Trim memory ignored while valid is low
// - Display on and trim enable exclusive
// - Mask ones program trim bits to one
// - Mask command: seven mask, two id bits
// - Shared opcodes act as trim when enabled
// - Icon show gates fixed rows in partial
`timescale 1ns/1ps
module lcd_window_cmd #(
  parameter [7:0] OP_PART_START = 8'hf2,
  parameter [7:0] OP_PART_END = 8'hf3
) (
  input wire CLK,
  input wire RST_N,
  input wire CE,
  input wire HOST_WR,
  input wire HOST_CD,
  input wire [7:0] HOST_DATA,
  input wire PTR_LOAD,
  input wire [6:0] PTR_COL,
  input wire [7:0] PTR_ROW,
  input wire PARTIAL_MODE,
  input wire [3:0] FIXED_TOP,
  input wire [3:0] FIXED_BOTTOM,
  input wire ADDR_ORDER,
  input wire ROW_REVERSE,
  input wire BOUNDARY_STEP,
  input wire TRIM_DONE,
  input wire [6:0] TRIM_MEM,
  output reg [1:0] BIAS_RATIO,
  output reg [7:0] COM_END,
  output reg [7:0] PART_START,
  output reg [7:0] PART_END,
  output reg [8:0] MUX_RATE,
  output reg WINDOW_MODE,
  output reg DISPLAY_ON,
  output reg COLUMN_MIRROR,
  output reg ICON_SHOW,
  output reg RAM_WE,
  output reg [6:0] RAM_COL,
  output reg [7:0] RAM_ROW,
  output reg [7:0] RAM_DATA,
  output reg [6:0] COL_PTR,
  output reg [7:0] ROW_PTR,
  output reg TRIM_EN,
  output reg [2:0] TRIM_OP,
  output reg TRIM_VALID,
  output reg [6:0] TRIM_PROG,
  output reg [6:0] TRIM_MASK,
  output reg [1:0] TRIM_ID_MASK,
  output reg [6:0] TRIM_VALUE,
  output reg [7:0] TRIM_POT1,
  output reg [7:0] TRIM_POT2,
  output reg [7:0] TRIM_WTIMER,
  output reg [7:0] TRIM_RTIMER
);
`include "lcd_cmd_consts.vh"
  localparam [1:0] ST_OP = 2'd0;
  localparam [1:0] ST_P1 = 2'd1;
  localparam [1:0] ST_P2 = 2'd2;

  reg [1:0] state;
  reg [7:0] opcode;
  reg [6:0] win_col_start;
  reg [6:0] win_col_end;
  reg [7:0] win_row_start;
  reg [7:0] win_row_end;
  wire [6:0] next_col;
  wire [7:0] next_row;
  wire cmd_wr;
  wire data_wr;
  wire in_window;
  wire trim_done_clear;
  wire [8:0] next_mux;
  wire [8:0] fixed_sum;

  // Opcodes that take parameter bytes
  function has_param;
    input [7:0] op;
    begin
      has_param = (op == `OP_COM_END) || (op == `OP_TRIM_CTRL) ||
        (op == `OP_TRIM_MASK) || (op == OP_PART_START) ||
        (op == OP_PART_END) || (op == `OP_WIN_COL_START) ||
        (op == `OP_WIN_ROW_START) || (op == `OP_WIN_COL_END) ||
        (op == `OP_WIN_ROW_END);
    end
  endfunction

  function op_match;
    input [7:0] data;
    input [7:0] mask;
    input [7:0] op;
    begin
      op_match = ((data & mask) == op);
    end
  endfunction

  assign cmd_wr = CE && HOST_WR && !HOST_CD;
  assign data_wr = CE && HOST_WR && HOST_CD;
  // Window hit uses the logical pointer, before mirroring
  assign in_window = (COL_PTR >= win_col_start) &&
    (COL_PTR <= win_col_end) && (ROW_PTR >= win_row_start) &&
    (ROW_PTR <= win_row_end);
  assign fixed_sum = {4'h0, FIXED_TOP} + {4'h0, FIXED_BOTTOM};
  // Partial mux: start minus end plus one, plus doubled fixed rows while icons show
  assign next_mux = PARTIAL_MODE ?
    ({1'b0, PART_START} - {1'b0, PART_END} + 9'h001 +
    (ICON_SHOW ? {fixed_sum[7:0], 1'b0} : 9'h000)) :
    ({1'b0, COM_END} + 9'h001);
  assign trim_done_clear = CE && TRIM_DONE;

  window_addr_step u_step (
    .col(COL_PTR),
    .row(ROW_PTR),
    .win_col_start(win_col_start),
    .win_col_end(win_col_end),
    .win_row_start(win_row_start),
    .win_row_end(win_row_end),
    .outside_mode(WINDOW_MODE),
    .vertical_order(ADDR_ORDER),
    .row_direction_reverse(ROW_REVERSE),
    .boundary_step_select(BOUNDARY_STEP),
    .next_col(next_col),
    .next_row(next_row)
  );

  // Command and parameter decoding
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= ST_OP;
      opcode <= 8'h00;
      BIAS_RATIO <= `RST_BIAS;
      COM_END <= `RST_COM_END;
      PART_START <= `RST_PART_START;
      PART_END <= `RST_PART_END;
      win_col_start <= 7'h00;
      win_row_start <= 8'h00;
      win_col_end <= `RST_WIN_COL_END;
      win_row_end <= `RST_WIN_ROW_END;
      WINDOW_MODE <= 1'b0;
      DISPLAY_ON <= 1'b0;
      COLUMN_MIRROR <= 1'b0;
      ICON_SHOW <= 1'b0;
      TRIM_EN <= 1'b0;
      TRIM_OP <= `TRIM_OP_IDLE;
      TRIM_VALID <= 1'b0;
      TRIM_MASK <= 7'h00;
      TRIM_ID_MASK <= 2'h0;
      TRIM_POT1 <= 8'h00;
      TRIM_POT2 <= 8'h00;
      TRIM_WTIMER <= 8'h00;
      TRIM_RTIMER <= 8'h00;
    end else if (CE) begin
      // Completion clears enable; a new enabling write below wins
      if (trim_done_clear) begin
        TRIM_EN <= 1'b0;
      end
      if (data_wr) begin
        state <= ST_OP;
      end else if (cmd_wr) begin
        case (state)
          ST_OP: begin
            opcode <= HOST_DATA;
            if (has_param(HOST_DATA)) begin
              state <= ST_P1;
            end
            if (op_match(HOST_DATA, `OP_BIAS_MASK, `OP_BIAS)) begin
              BIAS_RATIO <= HOST_DATA[1:0];
            end
            if (op_match(HOST_DATA, `OP_WIN_MODE_MASK, `OP_WIN_MODE)) begin
              WINDOW_MODE <= HOST_DATA[0];
            end
            if (op_match(HOST_DATA, `OP_DISP_EN_MASK, `OP_DISP_EN)) begin
              // Display cannot turn on while trimming is enabled
              DISPLAY_ON <= HOST_DATA[0] && !TRIM_EN;
            end
            if (op_match(HOST_DATA, `OP_MAP_MASK, `OP_MAP)) begin
              COLUMN_MIRROR <= HOST_DATA[1];
              ICON_SHOW <= HOST_DATA[0];
            end
          end
          ST_P1: begin
            state <= ST_OP;
            if (opcode == `OP_COM_END) begin
              COM_END <= HOST_DATA;
            end
            if (opcode == OP_PART_START) begin
              PART_START <= HOST_DATA;
            end
            if (opcode == OP_PART_END) begin
              PART_END <= HOST_DATA;
            end
            if (opcode == `OP_TRIM_CTRL) begin
              TRIM_OP <= HOST_DATA[2:0];
              TRIM_VALID <= HOST_DATA[`TRIM_VALID_BIT];
              // Trimming cannot start while the display is on
              TRIM_EN <= HOST_DATA[`TRIM_EN_BIT] && !DISPLAY_ON;
            end
            if (opcode == `OP_TRIM_MASK) begin
              if (TRIM_EN) begin
                TRIM_MASK <= HOST_DATA[6:0];
              end
              state <= ST_P2;
            end
            if (TRIM_EN) begin
              // Shared opcodes carry trim pots and timers
              if (opcode == `OP_WIN_COL_START) begin
                TRIM_POT1 <= HOST_DATA;
              end
              if (opcode == `OP_WIN_ROW_START) begin
                TRIM_POT2 <= HOST_DATA;
              end
              if (opcode == `OP_WIN_COL_END) begin
                TRIM_WTIMER <= HOST_DATA;
              end
              if (opcode == `OP_WIN_ROW_END) begin
                TRIM_RTIMER <= HOST_DATA;
              end
            end else begin
              if (opcode == `OP_WIN_COL_START) begin
                win_col_start <= HOST_DATA[6:0];
              end
              if (opcode == `OP_WIN_ROW_START) begin
                win_row_start <= HOST_DATA;
              end
              if (opcode == `OP_WIN_COL_END) begin
                win_col_end <= HOST_DATA[6:0];
              end
              if (opcode == `OP_WIN_ROW_END) begin
                win_row_end <= HOST_DATA;
              end
            end
          end
          ST_P2: begin
            // Third byte of the mask command
            state <= ST_OP;
            if (TRIM_EN) begin
              TRIM_ID_MASK <= HOST_DATA[1:0];
            end
          end
          default: begin
            state <= ST_OP;
          end
        endcase
      end
    end
  end

  // Pointer, RAM write and derived outputs
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      COL_PTR <= 7'h00;
      ROW_PTR <= 8'h00;
      RAM_WE <= 1'b0;
      RAM_COL <= 7'h00;
      RAM_ROW <= 8'h00;
      RAM_DATA <= 8'h00;
      MUX_RATE <= `RST_MUX_RATE;
      TRIM_PROG <= 7'h00;
      TRIM_VALUE <= 7'h00;
    end else if (CE) begin
      MUX_RATE <= next_mux;
      TRIM_VALUE <= TRIM_VALID ? TRIM_MEM : 7'h00;
      TRIM_PROG <= (TRIM_EN && TRIM_OP == `TRIM_OP_PROGRAM) ?
        TRIM_MASK : 7'h00;
      RAM_WE <= 1'b0;
      // A pointer load wins over the data advance
      if (PTR_LOAD) begin
        COL_PTR <= PTR_COL;
        ROW_PTR <= PTR_ROW;
      end else if (data_wr) begin
        COL_PTR <= next_col;
        ROW_PTR <= next_row;
      end
      if (data_wr) begin
        // Outside mode keeps the window's contents untouched
        RAM_WE <= !(WINDOW_MODE && in_window);
        RAM_COL <= COLUMN_MIRROR ? (`COL_MAX - COL_PTR) : COL_PTR;
        RAM_ROW <= ROW_PTR;
        RAM_DATA <= HOST_DATA;
      end
    end
  end
endmodule

// [src/window_addr_step.v]
// Next column and row pointer for one data write
`timescale 1ns/1ps
module window_addr_step (
  input wire [6:0] col,
  input wire [7:0] row,
  input wire [6:0] win_col_start,
  input wire [6:0] win_col_end,
  input wire [7:0] win_row_start,
  input wire [7:0] win_row_end,
  input wire outside_mode,
  input wire vertical_order,
  input wire row_direction_reverse,
  input wire boundary_step_select,
  output reg [6:0] next_col,
  output reg [7:0] next_row
);
`include "lcd_cmd_consts.vh"
  reg [6:0] col_lo;
  reg [6:0] col_hi;
  reg [7:0] row_lo;
  reg [7:0] row_hi;
  reg col_at_end;
  reg row_at_end;
  reg [6:0] col_step;
  reg [7:0] row_step;
  reg [6:0] col_wrap;
  reg [7:0] row_wrap;
  always @* begin
    // Bounds follow the window in inside mode, the full map otherwise
    col_lo = outside_mode ? 7'h00 : win_col_start;
    col_hi = outside_mode ? `COL_MAX : win_col_end;
    row_lo = outside_mode ? 8'h00 : win_row_start;
    row_hi = outside_mode ? `ROW_MAX : win_row_end;
    col_at_end = (col == col_hi);
    col_wrap = col_lo;
    col_step = col_at_end ? col_wrap : col + 7'h01;
    // Rows run toward the end bound, or back toward the start
    if (row_direction_reverse) begin
      row_at_end = (row == row_lo);
      row_wrap = row_hi;
      row_step = row_at_end ? row_wrap : row - 8'h01;
    end else begin
      row_at_end = (row == row_hi);
      row_wrap = row_lo;
      row_step = row_at_end ? row_wrap : row + 8'h01;
    end
    next_col = col;
    next_row = row;
    if (vertical_order) begin
      next_row = row_step;
      if (row_at_end && boundary_step_select) begin
        next_col = col_step;
      end
    end else begin
      next_col = col_step;
      if (col_at_end && boundary_step_select) begin
        next_row = row_step;
      end
    end
  end
endmodule

// [tb/host_port_model.sv]
// Host side model writing command and data bytes
`timescale 1ns/1ps
module host_port_model (
  input wire CLK,
  output reg HOST_WR,
  output reg HOST_CD,
  output reg [7:0] HOST_DATA
);
  initial begin
    HOST_WR = 1'b0;
    HOST_CD = 1'b0;
    HOST_DATA = 8'h00;
  end
  // One byte over one edge, then a released cycle
  task send(input cd, input [7:0] d);
    begin
      HOST_WR = 1'b1;
      HOST_CD = cd;
      HOST_DATA = d;
      @(posedge CLK);
      #1 HOST_WR = 1'b0;
      HOST_DATA = ~d;
      @(posedge CLK);
      #1;
    end
  endtask
endmodule

// [tb/lcd_window_checker.sv]
// Assertions on the window and trim command block
`timescale 1ns/1ps
module lcd_window_checker (
  input wire CLK,
  input wire RST_N,
  input wire CE,
  input wire HOST_WR,
  input wire HOST_CD,
  input wire PTR_LOAD,
  input wire PARTIAL_MODE,
  input wire TRIM_DONE,
  input wire [6:0] TRIM_MEM,
  input wire [7:0] COM_END,
  input wire [8:0] MUX_RATE,
  input wire WINDOW_MODE,
  input wire DISPLAY_ON,
  input wire COLUMN_MIRROR,
  input wire RAM_WE,
  input wire [6:0] RAM_COL,
  input wire [6:0] COL_PTR,
  input wire [7:0] ROW_PTR,
  input wire TRIM_EN,
  input wire TRIM_VALID,
  input wire [6:0] TRIM_VALUE
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  wire data_wr = CE && HOST_WR && HOST_CD;
  excl_flags_a: assert property (!(DISPLAY_ON && TRIM_EN))
    else $error("display and trim enable both set");
  trim_clear_a: assert property (CE && TRIM_DONE &&
    !(HOST_WR && !HOST_CD) |=> !TRIM_EN)
    else $error("trim enable kept after done");
  trim_value_a: assert property (CE |=> TRIM_VALUE ==
    ($past(TRIM_VALID) ? $past(TRIM_MEM) : 7'h00)) else $error("trim value");
  mux_full_a: assert property (CE && !PARTIAL_MODE |=>
    MUX_RATE == {1'b0, $past(COM_END)} + 9'h001) else $error("mux rate");
  ram_we_a: assert property (RAM_WE |-> $past(data_wr))
    else $error("write strobe without data byte");
  we_inside_a: assert property (data_wr && !WINDOW_MODE |=> RAM_WE)
    else $error("inside mode write dropped");
  ram_col_a: assert property (data_wr && !PTR_LOAD |=> RAM_COL ==
    ($past(COLUMN_MIRROR) ? 7'h7f - $past(COL_PTR) : $past(COL_PTR)))
    else $error("ram column");
  mode_keep_a: assert property ($changed(WINDOW_MODE) &&
    !$past(data_wr) && !$past(PTR_LOAD) |-> $stable(COL_PTR) &&
    $stable(ROW_PTR)) else $error("pointer moved on mode change");
  row_range_a: assert property (ROW_PTR <= 8'h9f)
    else $error("row pointer out of range");
  cover property (RAM_WE);
  cover property ($fell(TRIM_EN));
  cover property (CE && PARTIAL_MODE);
  cover property ($rose(WINDOW_MODE));
endmodule
bind lcd_window_cmd lcd_window_checker u_checker (
  .CLK(CLK), .RST_N(RST_N), .CE(CE), .HOST_WR(HOST_WR), .HOST_CD(HOST_CD),
  .PTR_LOAD(PTR_LOAD), .PARTIAL_MODE(PARTIAL_MODE), .TRIM_DONE(TRIM_DONE),
  .TRIM_MEM(TRIM_MEM), .COM_END(COM_END), .MUX_RATE(MUX_RATE),
  .WINDOW_MODE(WINDOW_MODE), .DISPLAY_ON(DISPLAY_ON), .RAM_WE(RAM_WE),
  .COLUMN_MIRROR(COLUMN_MIRROR), .RAM_COL(RAM_COL), .COL_PTR(COL_PTR),
  .ROW_PTR(ROW_PTR), .TRIM_EN(TRIM_EN), .TRIM_VALID(TRIM_VALID),
  .TRIM_VALUE(TRIM_VALUE)
);

// [tb/testbench.sv]
// Testbench for the window and trim command block
`timescale 1ns/1ps
module testbench;
  reg CLK, RST_N, PTR_LOAD, PARTIAL_MODE, ADDR_ORDER, ROW_REVERSE;
  reg BOUNDARY_STEP, TRIM_DONE, CE;
  reg [6:0] PTR_COL, TRIM_MEM;
  reg [7:0] PTR_ROW;
  reg [3:0] FIXED_TOP, FIXED_BOTTOM;
  wire HOST_WR, HOST_CD, DISPLAY_ON, RAM_WE, TRIM_EN;
  wire WINDOW_MODE, ICON_SHOW, TRIM_VALID;
  wire [7:0] HOST_DATA, COM_END, PART_START, PART_END, RAM_DATA, ROW_PTR;
  wire [7:0] POT1, POT2, WTIMER, RTIMER, RAM_ROW;
  wire [6:0] RAM_COL, COL_PTR, TRIM_PROG, TRIM_MASK, TRIM_VALUE;
  wire [8:0] MUX_RATE;
  wire [2:0] TRIM_OP;
  wire [1:0] BIAS_RATIO, TRIM_ID_MASK;
  integer n_errors, checks_done, cyc, n_we, i;
  host_port_model u_host (.CLK(CLK), .HOST_WR(HOST_WR), .HOST_CD(HOST_CD),
    .HOST_DATA(HOST_DATA));
  lcd_window_cmd u_dut (.CLK(CLK), .RST_N(RST_N), .CE(CE),
    .HOST_WR(HOST_WR), .HOST_CD(HOST_CD), .HOST_DATA(HOST_DATA),
    .PTR_LOAD(PTR_LOAD), .PTR_COL(PTR_COL), .PTR_ROW(PTR_ROW),
    .PARTIAL_MODE(PARTIAL_MODE), .FIXED_TOP(FIXED_TOP),
    .FIXED_BOTTOM(FIXED_BOTTOM), .ADDR_ORDER(ADDR_ORDER),
    .ROW_REVERSE(ROW_REVERSE), .BOUNDARY_STEP(BOUNDARY_STEP),
    .TRIM_DONE(TRIM_DONE), .TRIM_MEM(TRIM_MEM), .BIAS_RATIO(BIAS_RATIO),
    .COM_END(COM_END), .PART_START(PART_START), .PART_END(PART_END),
    .MUX_RATE(MUX_RATE), .WINDOW_MODE(WINDOW_MODE),
    .DISPLAY_ON(DISPLAY_ON), .COLUMN_MIRROR(), .ICON_SHOW(ICON_SHOW),
    .RAM_WE(RAM_WE), .RAM_COL(RAM_COL), .RAM_ROW(RAM_ROW),
    .RAM_DATA(RAM_DATA), .COL_PTR(COL_PTR), .ROW_PTR(ROW_PTR),
    .TRIM_EN(TRIM_EN), .TRIM_OP(TRIM_OP), .TRIM_VALID(TRIM_VALID),
    .TRIM_PROG(TRIM_PROG), .TRIM_MASK(TRIM_MASK),
    .TRIM_ID_MASK(TRIM_ID_MASK), .TRIM_VALUE(TRIM_VALUE),
    .TRIM_POT1(POT1), .TRIM_POT2(POT2), .TRIM_WTIMER(WTIMER),
    .TRIM_RTIMER(RTIMER));
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  task chk(input [8:0] got, input [8:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("BAD %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task c(input [7:0] d);
    u_host.send(1'b0, d);
  endtask
  task w(input [7:0] d);
    u_host.send(1'b1, d);
  endtask
  task ld(input [6:0] col, input [7:0] row);
    begin
      PTR_COL = col;
      PTR_ROW = row;
      PTR_LOAD = 1'b1;
      @(posedge CLK);
      #1 PTR_LOAD = 1'b0;
    end
  endtask
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc = cyc + 1;
    if (RAM_WE === 1'b1) n_we = n_we + 1;
    if (cyc == 3000) begin
      n_errors = n_errors + 1;
      stop_test;
    end
  end
  initial begin
    {RST_N, PTR_LOAD, PARTIAL_MODE, ADDR_ORDER, ROW_REVERSE} = 5'h00;
    {BOUNDARY_STEP, TRIM_DONE, PTR_COL, TRIM_MEM, PTR_ROW} = 24'h000000;
    {FIXED_TOP, FIXED_BOTTOM} = 8'h00;
    {n_errors, checks_done, cyc, n_we} = 128'h0;
    CE = 1'b1;
    repeat (12) @(posedge CLK);
    #1 RST_N = 1'b1;
    @(posedge CLK);
    #1 chk(MUX_RATE, 9'h0a0);
    for (i = 0; i < 4; i = i + 1) begin
      c(8'he8 | i[7:0]);
      chk(BIAS_RATIO, i[1:0]);
    end
    c(8'hf1);
    c(8'h7f);
    chk(COM_END, 9'h07f);
    chk(MUX_RATE, 9'h080);
    c(8'hf1);
    w(8'h11);
    c(8'h10);
    chk(COM_END, 9'h07f);
    $display("bias and com end tests done");
    {PARTIAL_MODE, FIXED_TOP, FIXED_BOTTOM} = 9'h121;
    c(8'hf2);
    c(8'h20);
    c(8'hf3);
    c(8'h10);
    c(8'hc1);
    chk(PART_START, 9'h020);
    chk(PART_END, 9'h010);
    chk(MUX_RATE, 9'h017);
    chk(ICON_SHOW, 9'h001);
    c(8'hc0);
    chk(MUX_RATE, 9'h011);
    c(8'he8);
    chk(BIAS_RATIO, 9'h000);
    PARTIAL_MODE = 1'b0;
    CE = 1'b0;
    c(8'he9);
    w(8'h5a);
    chk(BIAS_RATIO, 9'h000);
    chk(COL_PTR, 9'h001);
    CE = 1'b1;
    $display("partial tests done");
    c(8'hf4);
    c(8'h02);
    c(8'hf5);
    c(8'h03);
    c(8'hf6);
    c(8'h04);
    c(8'hf7);
    c(8'h04);
    BOUNDARY_STEP = 1'b1;
    ld(7'h02, 8'h03);
    n_we = 0;
    w(8'ha1);
    w(8'ha2);
    w(8'ha3);
    chk(n_we[8:0], 9'h003);
    chk(RAM_DATA, 9'h0a3);
    chk(COL_PTR, 9'h002);
    chk(ROW_PTR, 9'h004);
    ADDR_ORDER = 1'b1;
    w(8'hb1);
    chk(COL_PTR, 9'h003);
    chk(ROW_PTR, 9'h003);
    ROW_REVERSE = 1'b1;
    ld(7'h03, 8'h04);
    w(8'hb2);
    chk(ROW_PTR, 9'h003);
    {ROW_REVERSE, ADDR_ORDER, BOUNDARY_STEP} = 3'h0;
    ld(7'h04, 8'h03);
    w(8'hb3);
    chk(COL_PTR, 9'h002);
    chk(ROW_PTR, 9'h003);
    BOUNDARY_STEP = 1'b1;
    c(8'hc2);
    ld(7'h02, 8'h03);
    w(8'hc1);
    chk(RAM_COL, 9'h07d);
    chk(RAM_ROW, 9'h003);
    c(8'hc0);
    c(8'hf9);
    chk(WINDOW_MODE, 9'h001);
    chk(COL_PTR, 9'h003);
    ld(7'h03, 8'h03);
    n_we = 0;
    w(8'hd1);
    chk(n_we[8:0], 9'h000);
    chk(COL_PTR, 9'h004);
    ld(7'h7f, 8'h9f);
    w(8'hd2);
    chk(n_we[8:0], 9'h001);
    chk(COL_PTR, 9'h000);
    chk(ROW_PTR, 9'h000);
    c(8'hf8);
    $display("window tests done");
    TRIM_MEM = 7'h2a;
    chk(TRIM_VALUE, 9'h000);
    c(8'hb8);
    c(8'h08);
    c(8'hf4);
    c(8'h55);
    c(8'hf5);
    c(8'h77);
    c(8'hf6);
    c(8'h88);
    c(8'hf7);
    c(8'h66);
    chk(POT1, 9'h055);
    chk(POT2, 9'h077);
    chk(WTIMER, 9'h088);
    chk(RTIMER, 9'h066);
    for (i = 0; i < 4; i = i + 1) begin
      c(8'hb8);
      c(8'h08 | i[7:0]);
      chk(TRIM_OP, i[2:0]);
    end
    c(8'hb9);
    c(8'h35);
    c(8'h02);
    chk(TRIM_MASK, 9'h035);
    chk(TRIM_ID_MASK, 9'h002);
    chk(TRIM_PROG, 9'h035);
    c(8'ha9);
    chk(DISPLAY_ON, 9'h000);
    TRIM_DONE = 1'b1;
    @(posedge CLK);
    #1 TRIM_DONE = 1'b0;
    chk(TRIM_EN, 9'h000);
    c(8'ha9);
    c(8'hb8);
    c(8'h08);
    chk(TRIM_EN, 9'h000);
    c(8'hb8);
    c(8'h10);
    chk(TRIM_VALID, 9'h001);
    chk(TRIM_VALUE, 9'h02a);
    $display("trim tests done");
    stop_test;
  end
endmodule
